// file: common/emc_defs.svh
/*
  Constants for the statistics counter bank: window sizes, counter offsets,
  counter indices, threshold crossing values and the VLAN tag allowance.
  Assumes it is included by its bare name from every file that needs it.
*/
`ifndef EMC_DEFS_SVH
`define EMC_DEFS_SVH

`define EMC_IO_WINDOW_BYTES   10'h100
`define EMC_MEM_WINDOW_BYTES  10'h200
`define EMC_ADDR_W            9
`define EMC_NUM_CNT           25
`define EMC_VLAN_TAG_OCTETS   32'h0000_0004
`define EMC_THRESH_16         16'hc000
`define EMC_THRESH_32         32'hc000_0000

`define EMC_OFF_RX_OCTETS       8'ha8
`define EMC_OFF_RX_MC_OCTETS    8'hac
`define EMC_OFF_RX_BC_OCTETS    8'hb0
`define EMC_OFF_RX_FRAMES       8'hb4
`define EMC_OFF_RX_MC_FRAMES    8'hb8
`define EMC_OFF_RX_BC_FRAMES    8'hbc
`define EMC_OFF_RX_PAUSE        8'hc6
`define EMC_OFF_RX_OVERSIZE     8'hc8
`define EMC_OFF_RX_LEN_ERR      8'hca
`define EMC_OFF_RX_FCS_ERR      8'hcc
`define EMC_OFF_RX_OVERRUN      8'hce
`define EMC_OFF_TX_OCTETS       8'hd0
`define EMC_OFF_TX_MC_OCTETS    8'hd4
`define EMC_OFF_TX_BC_OCTETS    8'hd8
`define EMC_OFF_TX_FRAMES       8'hdc
`define EMC_OFF_TX_MC_FRAMES    8'he0
`define EMC_OFF_TX_DEFERRED     8'he4
`define EMC_OFF_TX_LATE_COLL    8'he8
`define EMC_OFF_TX_MULTI_COLL   8'hec
`define EMC_OFF_TX_ONE_COLL     8'hf0
`define EMC_OFF_TX_BC_FRAMES    8'hf6
`define EMC_OFF_TX_CARRIER      8'hf8
`define EMC_OFF_TX_PAUSE        8'hfa
`define EMC_OFF_TX_XS_COLL      8'hfc
`define EMC_OFF_TX_XS_DEFER     8'hfe

`define EMC_IX_RX_BC_OCTETS   2
`define EMC_IX_RX_BC_FRAMES   5
`define EMC_IX_TX_BC_FRAMES   17

`endif

// file: common/emc_pkg.sv
/*
  Types shared by the statistics counter bank.
  Assumes emc_defs.svh is on the include path.
*/
`include "emc_defs.svh"

package emc_pkg;

  typedef logic [`EMC_NUM_CNT-1:0] emc_cntvec_t;

  // Bank-level state: read answer and the sticky threshold flag
  typedef struct packed {
    logic [31:0] rdata;
    logic        rvalid;
    logic        flag;
  } emc_bank_s;

endpackage

// file: rtl/emc_counter.sv
/*
  One wrapping statistics counter with byte-writable contents and a
  threshold crossing pulse.
  Assumes a single clock and a synchronous active-high reset.
*/
`timescale 1ns/1ns
`include "emc_defs.svh"

module emc_counter #(
  parameter int WIDTH = 16
) (
  input  wire logic               clock,
  input  wire logic               sys_rst,
  input  wire logic               count_en,
  input  wire logic               add_en,
  input  wire logic [WIDTH-1:0]   add_amt,
  input  wire logic               wr_en,
  input  wire logic [WIDTH/8-1:0] wr_be,
  input  wire logic [WIDTH-1:0]   wr_data,
  output logic      [WIDTH-1:0]   value,
  output logic                    thresh_hit
);

  localparam logic [WIDTH-1:0] THRESH = (WIDTH == 32) ? WIDTH'(`EMC_THRESH_32)
                                                      : WIDTH'(`EMC_THRESH_16);

  typedef struct packed {
    logic [WIDTH-1:0] count;
    logic             hit;
  } emc_cnt_s;

  emc_cnt_s         st_ff;
  emc_cnt_s         nxt_st;
  logic [WIDTH-1:0] sum;

  // Software write wins over a same-cycle event so a cleared counter reads as written
  always_comb begin
    nxt_st = st_ff;
    nxt_st.hit = 1'b0;
    sum = st_ff.count + add_amt;
    if (wr_en) begin
      for (int b = 0; b < WIDTH / 8; b++) begin
        if (wr_be[b]) begin
          nxt_st.count[b*8 +: 8] = wr_data[b*8 +: 8];
        end
      end
    end else if (count_en && add_en) begin
      nxt_st.count = sum;
      // A multi-octet add may step over the threshold or even wrap past it
      nxt_st.hit = (st_ff.count < THRESH) && ((sum >= THRESH) || (sum < st_ff.count));
    end
  end

  // State register
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign value = st_ff.count;
  assign thresh_hit = st_ff.hit;

  a_reset_zero: assert property (@(posedge clock) disable iff (sys_rst)
    $past(sys_rst) |-> (value == '0) && !thresh_hit)
    else $error("counter not zero after reset");

  a_hold_gated: assert property (@(posedge clock) disable iff (sys_rst)
    (!count_en || !add_en) && !wr_en |=> $stable(value))
    else $error("gated counter changed");

  a_add_wraps: assert property (@(posedge clock) disable iff (sys_rst)
    count_en && add_en && !wr_en |=> value == WIDTH'($past(value) + $past(add_amt)))
    else $error("counter did not add modulo its width");

  a_full_to_zero: assert property (@(posedge clock) disable iff (sys_rst)
    count_en && add_en && !wr_en && (add_amt == WIDTH'(1)) && (value == '1) |=> value == '0)
    else $error("full counter did not roll to zero");

  a_thresh_reach: assert property (@(posedge clock) disable iff (sys_rst)
    count_en && add_en && !wr_en && (add_amt == WIDTH'(1)) && (value == THRESH - WIDTH'(1))
    |=> thresh_hit && (value == THRESH))
    else $error("threshold reach not flagged");

  a_hit_cause: assert property (@(posedge clock) disable iff (sys_rst)
    thresh_hit |-> $past(count_en) && $past(add_en) && !$past(wr_en))
    else $error("threshold pulse without counted event");

endmodule

// file: rtl/emc_stats_bank.sv
/*
  Ethernet statistics counter bank: 25 frame, octet and error counters
  behind the slave register window, with a sticky threshold flag.
  Assumes the MAC event inputs and the register port run on clock; the
  MAC drives one-cycle frame-end pulses with their qualifiers valid alongside.
*/
`timescale 1ns/1ns
`include "emc_defs.svh"

module emc_stats_bank (
  input  wire logic                   clock,
  input  wire logic                   sys_rst,
  // Register window
  input  wire logic                   io_space_en,
  input  wire logic                   mem_space_en,
  input  wire logic                   reg_io_sel,
  input  wire logic                   reg_mem_sel,
  input  wire logic [`EMC_ADDR_W-1:0] reg_addr,
  input  wire logic                   reg_rd,
  input  wire logic                   reg_wr,
  input  wire logic [3:0]             reg_be,
  input  wire logic [31:0]            reg_wdata,
  output logic      [31:0]            reg_rdata,
  output logic                        reg_rvalid,
  // Control and status bits
  input  wire logic                   counters_global_enable,
  input  wire emc_pkg::emc_cntvec_t   counter_mask_reg,
  input  wire logic                   threshold_flag_clr,
  output logic                        counter_threshold_flag,
  // Receive side events
  input  wire logic                   rx_frame_done,
  input  wire logic [15:0]            rx_frame_len,
  input  wire logic                   rx_dest_bcast,
  input  wire logic                   rx_dest_mcast,
  input  wire logic                   rx_vlan_stripped,
  input  wire logic                   rx_is_pause,
  input  wire logic                   rx_too_long,
  input  wire logic                   rx_fcs_err,
  input  wire logic                   rx_len_err,
  input  wire logic                   rx_align_err,
  input  wire logic                   rx_overrun,
  // Transmit side events
  input  wire logic                   tx_frame_done,
  input  wire logic                   tx_ok,
  input  wire logic [15:0]            tx_frame_len,
  input  wire logic                   tx_dest_bcast,
  input  wire logic                   tx_dest_mcast,
  input  wire logic                   tx_vlan_inserted,
  input  wire logic                   tx_is_pause,
  input  wire logic                   tx_deferred_ev,
  input  wire logic                   tx_late_coll_ev,
  input  wire logic                   tx_multi_coll_ev,
  input  wire logic                   tx_one_coll_ev,
  input  wire logic                   tx_carrier_loss_ev,
  input  wire logic                   tx_excess_coll_ev,
  input  wire logic                   tx_excess_defer_ev
);

  localparam int N = `EMC_NUM_CNT;

  // Offsets of every counter, in index order
  localparam logic [7:0] OFFS [N] = '{
    `EMC_OFF_RX_OCTETS,   `EMC_OFF_RX_MC_OCTETS, `EMC_OFF_RX_BC_OCTETS,
    `EMC_OFF_RX_FRAMES,   `EMC_OFF_RX_MC_FRAMES, `EMC_OFF_RX_BC_FRAMES,
    `EMC_OFF_RX_OVERSIZE, `EMC_OFF_RX_FCS_ERR,   `EMC_OFF_TX_OCTETS,
    `EMC_OFF_TX_MC_OCTETS, `EMC_OFF_TX_BC_OCTETS, `EMC_OFF_TX_FRAMES,
    `EMC_OFF_TX_MC_FRAMES, `EMC_OFF_TX_DEFERRED, `EMC_OFF_TX_LATE_COLL,
    `EMC_OFF_TX_MULTI_COLL, `EMC_OFF_TX_ONE_COLL, `EMC_OFF_TX_BC_FRAMES,
    `EMC_OFF_TX_CARRIER,  `EMC_OFF_TX_XS_COLL,   `EMC_OFF_RX_OVERRUN,
    `EMC_OFF_RX_LEN_ERR,  `EMC_OFF_RX_PAUSE,     `EMC_OFF_TX_PAUSE,
    `EMC_OFF_TX_XS_DEFER
  };

  // Which counters are double words
  localparam bit WIDE [N] = '{
    1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1,
    1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0,
    1'b0, 1'b0, 1'b0, 1'b0, 1'b0
  };

  // Byte lanes that a counter occupies in its word
  function automatic logic [3:0] lane_mask(input logic [7:0] off, input bit wide);
    logic [3:0] m;
    m = 4'h0;
    if (wide) begin
      m = 4'hf;
    end else if (off[1]) begin
      m = 4'hc;
    end else begin
      m = 4'h3;
    end
    return m;
  endfunction

  // Does the current address select the word holding this counter
  function automatic logic word_match(input logic [7:0] off,
                                      input logic [`EMC_ADDR_W-1:0] addr);
    return (addr[7:2] == off[7:2]);
  endfunction

  emc_pkg::emc_bank_s   st_ff;
  emc_pkg::emc_bank_s   nxt_st;
  emc_pkg::emc_cntvec_t cnt_en;
  emc_pkg::emc_cntvec_t inc;
  emc_pkg::emc_cntvec_t cnt_wr;
  emc_pkg::emc_cntvec_t cnt_hit;
  logic [31:0]          amt     [N];
  logic [31:0]          cnt_val [N];
  logic                 io_hit;
  logic                 mem_hit;
  logic                 map_hit;
  logic                 rx_good;
  logic [31:0]          rx_amt;
  logic [31:0]          tx_amt;
  logic                 tx_good;

  // Window decode; only the lower 256 bytes hold counters in either space
  assign io_hit  = reg_io_sel && io_space_en
                   && ({1'b0, reg_addr} < `EMC_IO_WINDOW_BYTES);
  assign mem_hit = reg_mem_sel && mem_space_en
                   && ({1'b0, reg_addr} < `EMC_MEM_WINDOW_BYTES);
  assign map_hit = (io_hit || mem_hit) && !reg_addr[8];

  // Count gate: global enable high and own mask bit low
  assign cnt_en = counters_global_enable ? ~counter_mask_reg : '0;

  // Good frame qualifiers; any error excludes a received frame from the good counts
  assign rx_good = rx_frame_done
                   && !(rx_too_long || rx_fcs_err || rx_len_err || rx_align_err || rx_overrun);
  assign tx_good = tx_frame_done && tx_ok;

  // Octet amounts always carry the tag, whichever side added or removed it
  assign rx_amt = {16'h0000, rx_frame_len}
                  + (rx_vlan_stripped ? `EMC_VLAN_TAG_OCTETS : 32'h0000_0000);
  assign tx_amt = {16'h0000, tx_frame_len}
                  + (tx_vlan_inserted ? `EMC_VLAN_TAG_OCTETS : 32'h0000_0000);

  // Event routing to each counter; multicast counts leave broadcast frames out
  always_comb begin
    for (int i = 0; i < N; i++) begin
      amt[i] = 32'h0000_0001;
    end
    inc = '0;
    inc[0]  = rx_good;
    amt[0]  = rx_amt;
    inc[1]  = rx_good && rx_dest_mcast && !rx_dest_bcast;
    amt[1]  = rx_amt;
    inc[2]  = rx_good && rx_dest_bcast;
    amt[2]  = rx_amt;
    inc[3]  = rx_good;
    inc[4]  = rx_good && rx_dest_mcast && !rx_dest_bcast;
    inc[5]  = rx_good && rx_dest_bcast;
    inc[6]  = rx_frame_done && rx_too_long;
    inc[7]  = rx_frame_done && rx_fcs_err && !rx_too_long && !rx_align_err;
    inc[8]  = tx_good;
    amt[8]  = tx_amt;
    inc[9]  = tx_good && tx_dest_mcast && !tx_dest_bcast;
    amt[9]  = tx_amt;
    inc[10] = tx_good && tx_dest_bcast;
    amt[10] = tx_amt;
    inc[11] = tx_good;
    inc[12] = tx_good && tx_dest_mcast && !tx_dest_bcast;
    inc[13] = tx_deferred_ev;
    inc[14] = tx_late_coll_ev;
    inc[15] = tx_multi_coll_ev;
    inc[16] = tx_one_coll_ev;
    inc[17] = tx_good && tx_dest_bcast;
    inc[18] = tx_carrier_loss_ev;
    inc[19] = tx_excess_coll_ev;
    inc[20] = rx_frame_done && rx_overrun;
    inc[21] = rx_frame_done && rx_len_err;
    inc[22] = rx_good && rx_is_pause;
    inc[23] = tx_good && tx_is_pause;
    inc[24] = tx_excess_defer_ev;
  end

  // One counter per statistic; narrow ones take their half of the word
  for (genvar i = 0; i < N; i++) begin : g_cnt
    localparam int W = WIDE[i] ? 32 : 16;
    logic [W-1:0]   wd;
    logic [W/8-1:0] wb;
    logic [W-1:0]   val;
    logic [3:0]     lanes;

    assign lanes = lane_mask(OFFS[i], WIDE[i]);
    if (W == 32) begin : g_word
      assign wd = reg_wdata;
      assign wb = reg_be;
    end else if (OFFS[i][1]) begin : g_hi
      assign wd = reg_wdata[31:16];
      assign wb = reg_be[3:2];
    end else begin : g_lo
      assign wd = reg_wdata[15:0];
      assign wb = reg_be[1:0];
    end
    assign cnt_wr[i] = reg_wr && map_hit && word_match(OFFS[i], reg_addr)
                       && ((reg_be & lanes) != 4'h0);

    emc_counter #(
      .WIDTH (W)
    ) u_cnt (
      .clock      (clock),
      .sys_rst    (sys_rst),
      .count_en   (cnt_en[i]),
      .add_en     (inc[i]),
      .add_amt    (amt[i][W-1:0]),
      .wr_en      (cnt_wr[i]),
      .wr_be      (wb),
      .wr_data    (wd),
      .value      (val),
      .thresh_hit (cnt_hit[i])
    );

    assign cnt_val[i] = 32'(val);
  end

  // Read answer one cycle after the strobe; unmapped words read as zero
  always_comb begin
    nxt_st = st_ff;
    nxt_st.rvalid = reg_rd;
    if (reg_rd) begin
      nxt_st.rdata = 32'h0000_0000;
      for (int i = 0; i < N; i++) begin
        if (map_hit && word_match(OFFS[i], reg_addr)) begin
          if (OFFS[i][1] && !WIDE[i]) begin
            nxt_st.rdata = nxt_st.rdata | {cnt_val[i][15:0], 16'h0000};
          end else begin
            nxt_st.rdata = nxt_st.rdata | cnt_val[i];
          end
        end
      end
    end
    // A new crossing beats a clear in the same cycle so no event is lost
    nxt_st.flag = (cnt_hit != '0) || (st_ff.flag && !threshold_flag_clr);
  end

  // State register
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata = st_ff.rdata;
  assign reg_rvalid = st_ff.rvalid;
  assign counter_threshold_flag = st_ff.flag;

  // Indices of the broadcast counters that the value checks below watch
  localparam int IX_RBF = `EMC_IX_RX_BC_FRAMES;
  localparam int IX_RBO = `EMC_IX_RX_BC_OCTETS;
  localparam int IX_TBF = `EMC_IX_TX_BC_FRAMES;

  a_flag_set: assert property (@(posedge clock) disable iff (sys_rst)
    (cnt_hit != '0) |=> counter_threshold_flag)
    else $error("threshold crossing did not set the flag");

  a_flag_sticky: assert property (@(posedge clock) disable iff (sys_rst)
    counter_threshold_flag && !threshold_flag_clr |=> counter_threshold_flag)
    else $error("threshold flag dropped without a clear");

  a_flag_clear: assert property (@(posedge clock) disable iff (sys_rst)
    threshold_flag_clr && (cnt_hit == '0) |=> !counter_threshold_flag)
    else $error("threshold flag survived a clear");

  a_global_gate: assert property (@(posedge clock) disable iff (sys_rst)
    !counters_global_enable && !reg_wr |=> $stable(cnt_val[IX_RBO]))
    else $error("counting enabled while globally disabled");

  a_mask_gate: assert property (@(posedge clock) disable iff (sys_rst)
    counter_mask_reg[IX_RBF] && !reg_wr |=> $stable(cnt_val[IX_RBF]))
    else $error("mask bit does not gate its counter");

  a_rx_bcast_frame: assert property (@(posedge clock) disable iff (sys_rst)
    inc[`EMC_IX_RX_BC_FRAMES] == (rx_frame_done && rx_dest_bcast && !rx_too_long
      && !rx_fcs_err && !rx_len_err && !rx_align_err && !rx_overrun))
    else $error("broadcast receive frame qualifier wrong");

  a_rx_bcast_oct: assert property (@(posedge clock) disable iff (sys_rst)
    inc[`EMC_IX_RX_BC_OCTETS] == inc[`EMC_IX_RX_BC_FRAMES])
    else $error("broadcast octets and frames disagree");

  a_tx_bcast_only: assert property (@(posedge clock) disable iff (sys_rst)
    inc[`EMC_IX_TX_BC_FRAMES] |-> tx_dest_bcast && tx_frame_done && tx_ok)
    else $error("non-broadcast frame counted as broadcast");

  a_vlan_octets: assert property (@(posedge clock) disable iff (sys_rst)
    rx_vlan_stripped |-> amt[0] == ({16'h0000, rx_frame_len} + `EMC_VLAN_TAG_OCTETS))
    else $error("stripped tag octets not counted");

  a_read_unmapped: assert property (@(posedge clock) disable iff (sys_rst)
    reg_rd && !map_hit |=> reg_rvalid && (reg_rdata == 32'h0000_0000))
    else $error("unmapped read returned data");

  a_read_answer: assert property (@(posedge clock) disable iff (sys_rst)
    reg_rd ##1 !reg_rd |-> reg_rvalid ##1 !reg_rvalid)
    else $error("read answer not exactly one cycle after strobe");

  a_rx_err_block: assert property (@(posedge clock) disable iff (sys_rst)
    rx_frame_done && (rx_too_long || rx_fcs_err || rx_len_err || rx_align_err || rx_overrun)
    |-> !inc[IX_RBF] && !inc[IX_RBO])
    else $error("errored frame reached a broadcast counter");

  a_rx_bc_step: assert property (@(posedge clock) disable iff (sys_rst)
    inc[IX_RBF] && cnt_en[IX_RBF] && !cnt_wr[IX_RBF]
    |=> cnt_val[IX_RBF][15:0] == $past(cnt_val[IX_RBF][15:0]) + 16'h0001)
    else $error("good broadcast frame not counted once");

  a_bc16_wrap: assert property (@(posedge clock) disable iff (sys_rst)
    inc[IX_RBF] && cnt_en[IX_RBF] && !cnt_wr[IX_RBF] && (cnt_val[IX_RBF][15:0] == 16'hffff)
    |=> cnt_val[IX_RBF][15:0] == 16'h0000)
    else $error("16-bit counter did not wrap to zero");

  a_tx_bc_step: assert property (@(posedge clock) disable iff (sys_rst)
    inc[IX_TBF] && cnt_en[IX_TBF] && !cnt_wr[IX_TBF]
    |=> cnt_val[IX_TBF][15:0] == $past(cnt_val[IX_TBF][15:0]) + 16'h0001)
    else $error("good broadcast transmit not counted once");

  a_thresh_16: assert property (@(posedge clock) disable iff (sys_rst)
    inc[IX_RBF] && cnt_en[IX_RBF] && !cnt_wr[IX_RBF]
    && (cnt_val[IX_RBF][15:0] == `EMC_THRESH_16 - 16'h0001) |-> ##2 counter_threshold_flag)
    else $error("16-bit threshold reach did not raise the flag");

  a_rx_oct_add: assert property (@(posedge clock) disable iff (sys_rst)
    inc[IX_RBO] && cnt_en[IX_RBO] && !cnt_wr[IX_RBO]
    |=> cnt_val[IX_RBO] == $past(cnt_val[IX_RBO]) + $past(amt[IX_RBO]))
    else $error("broadcast octets not added");

  a_tx_vlan_oct: assert property (@(posedge clock) disable iff (sys_rst)
    tx_vlan_inserted |-> amt[8] == ({16'h0000, tx_frame_len} + `EMC_VLAN_TAG_OCTETS))
    else $error("inserted tag octets not counted");

  a_bc32_wrap: assert property (@(posedge clock) disable iff (sys_rst)
    inc[IX_RBO] && cnt_en[IX_RBO] && !cnt_wr[IX_RBO] && (cnt_val[IX_RBO] > ~amt[IX_RBO])
    |=> cnt_val[IX_RBO] < $past(cnt_val[IX_RBO]))
    else $error("32-bit counter did not wrap past its top");

  a_thresh_32: assert property (@(posedge clock) disable iff (sys_rst)
    inc[IX_RBO] && cnt_en[IX_RBO] && !cnt_wr[IX_RBO] && (cnt_val[IX_RBO] < `EMC_THRESH_32)
    && (cnt_val[IX_RBO] + amt[IX_RBO] >= `EMC_THRESH_32) |-> ##2 counter_threshold_flag)
    else $error("32-bit threshold reach did not raise the flag");

  a_flag_reset: assert property (@(posedge clock) disable iff (sys_rst)
    $past(sys_rst) |-> !counter_threshold_flag && !reg_rvalid && (reg_rdata == 32'h0000_0000))
    else $error("status not clear after reset");

  a_wide_read: assert property (@(posedge clock) disable iff (sys_rst)
    reg_rd && map_hit && (reg_addr[7:0] == `EMC_OFF_RX_BC_OCTETS)
    |=> reg_rvalid && (reg_rdata == $past(cnt_val[IX_RBO])))
    else $error("mapped read returned the wrong counter");

  a_space_off: assert property (@(posedge clock) disable iff (sys_rst)
    reg_rd && !(io_space_en && reg_io_sel) && !(mem_space_en && reg_mem_sel)
    |=> reg_rvalid && (reg_rdata == 32'h0000_0000))
    else $error("read through a disabled window returned data");

endmodule

// file: testbench/emc_mac_model.sv
/*
  Far-end MAC event source: turns a frame request into a one-cycle
  frame-end pulse with its length and qualifier vector.
  Assumes requests are raised for one cycle just after a clock edge.
*/
`timescale 1ns/1ns

module emc_mac_model (
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        go_rx,
  input  wire logic        go_tx,
  input  wire logic [15:0] req_len,
  input  wire logic [8:0]  req_q,
  output logic             rx_done,
  output logic             tx_done,
  output logic      [15:0] frm_len,
  output logic      [8:0]  frm_q
);
  // Outside a frame length and qualifiers flip every cycle, so the bank
  // cannot lean on values left over from the last frame
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rx_done <= 1'b0;
      tx_done <= 1'b0;
      frm_len <= 16'h0000;
      frm_q   <= 9'h000;
    end else begin
      rx_done <= go_rx;
      tx_done <= go_tx;
      frm_len <= (go_rx | go_tx) ? req_len : ~frm_len;
      frm_q   <= (go_rx | go_tx) ? req_q : ~frm_q;
    end
  end
endmodule

// file: testbench/emc_stats_bank_tb.sv
/*
  Self-checking bench for the statistics counter bank: window reads and
  writes, frame events through the MAC model, wrap and threshold flag.
  Assumes emc_pkg and emc_mac_model are compiled first.
*/
`timescale 1ns/1ns

module emc_stats_bank_tb;
  localparam logic [8:0] BC = 9'h100;
  localparam logic [8:0] VL = 9'h040;
  logic                 clock = 1'b0;
  logic                 sys_rst = 1'b1;
  logic                 io_en = 1'b1;
  logic                 mem_en = 1'b1;
  logic                 io_sel = 1'b0;
  logic                 mem_sel = 1'b1;
  logic [8:0]           reg_addr = 9'h000;
  logic                 reg_rd = 1'b0;
  logic                 reg_wr = 1'b0;
  logic [3:0]           reg_be = 4'h0;
  logic [31:0]          reg_wdata = 32'h0;
  logic [31:0]          reg_rdata;
  logic                 reg_rvalid;
  logic                 gen = 1'b1;
  emc_pkg::emc_cntvec_t mask = '0;
  logic                 clr = 1'b0;
  logic                 flag;
  logic                 go_rx = 1'b0;
  logic                 go_tx = 1'b0;
  logic [15:0]          req_len = 16'h0;
  logic [8:0]           req_q = 9'h0;
  logic                 rx_done;
  logic                 tx_done;
  logic [15:0]          frm_len;
  logic [8:0]           frm_q;
  logic [6:0]           tx_ev = 7'h0;
  logic [31:0]          exp_q[$];
  logic [31:0]          oct;
  logic [15:0]          l;
  int                   error_cnt = 0;
  int                   checks = 0;
  int                   seed = 32'hb6e044b0;
  int                   n = 0;
  int                   i;

  emc_mac_model emc_mac_model_inst (.clock(clock), .sys_rst(sys_rst), .go_rx(go_rx),
    .go_tx(go_tx), .req_len(req_len), .req_q(req_q), .rx_done(rx_done),
    .tx_done(tx_done), .frm_len(frm_len), .frm_q(frm_q));

  emc_stats_bank emc_stats_bank_inst (.clock(clock), .sys_rst(sys_rst),
    .io_space_en(io_en), .mem_space_en(mem_en), .reg_io_sel(io_sel),
    .reg_mem_sel(mem_sel), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .reg_be(reg_be), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .counters_global_enable(gen), .counter_mask_reg(mask),
    .threshold_flag_clr(clr), .counter_threshold_flag(flag),
    .rx_frame_done(rx_done), .rx_frame_len(frm_len), .rx_dest_bcast(frm_q[8]),
    .rx_dest_mcast(frm_q[7]), .rx_vlan_stripped(frm_q[6]), .rx_is_pause(frm_q[5]),
    .rx_too_long(frm_q[4]), .rx_fcs_err(frm_q[3]), .rx_len_err(frm_q[2]),
    .rx_align_err(frm_q[1]), .rx_overrun(frm_q[0]), .tx_frame_done(tx_done),
    .tx_ok(frm_q[4]), .tx_frame_len(frm_len), .tx_dest_bcast(frm_q[3]),
    .tx_dest_mcast(frm_q[2]), .tx_vlan_inserted(frm_q[1]), .tx_is_pause(frm_q[0]),
    .tx_deferred_ev(tx_ev[0]), .tx_late_coll_ev(tx_ev[1]), .tx_multi_coll_ev(tx_ev[2]),
    .tx_one_coll_ev(tx_ev[3]), .tx_carrier_loss_ev(tx_ev[4]),
    .tx_excess_coll_ev(tx_ev[5]), .tx_excess_defer_ev(tx_ev[6]));

  // Clock at 20 MHz
  initial begin
    forever #25 clock = ~clock;
  end

  // Inputs always move a fixed 5 ns after the edge, clear of sampling
  task automatic tk;
    @(posedge clock);
    #5;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One read strobe; the answer is compared by the watcher below
  task automatic rd(input logic [8:0] a, input logic [31:0] e);
    tk;
    reg_addr = a;
    reg_rd = 1'b1;
    exp_q.push_back(e);
    tk;
    reg_rd = 1'b0;
  endtask

  task automatic wr(input logic [8:0] a, input logic [3:0] b, input logic [31:0] d);
    tk;
    reg_addr = a;
    reg_be = b;
    reg_wdata = d;
    reg_wr = 1'b1;
    tk;
    reg_wr = 1'b0;
  endtask

  task automatic frame(input logic tx, input logic [15:0] ln, input logic [8:0] q);
    tk;
    go_rx = ~tx;
    go_tx = tx;
    req_len = ln;
    req_q = q;
    tk;
    go_rx = 1'b0;
    go_tx = 1'b0;
  endtask

  task automatic conclude;
    chk("pending reads", 32'(exp_q.size()), 32'h0);
    if (error_cnt == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Read answers are a one-cycle pulse; look at them mid-cycle when settled
  always @(negedge clock) begin
    if (reg_rvalid === 1'b1)
      chk("reg_rdata", reg_rdata, exp_q.pop_front());
  end

  // Hang guard, far beyond the fewer than two hundred cycles the sequence needs
  initial begin
    #250000;
    error_cnt++;
    conclude;
  end

  initial begin
    repeat (20) tk;
    sys_rst = 1'b0;
    rd(9'h0b0, 32'h0);
    rd(9'h0f4, 32'h0);
    l = 16'h002e + (16'($random(seed)) & 16'h03ff);
    oct = 32'(l) + 32'h4;
    frame(1'b0, l, BC | VL);
    rd(9'h0b0, oct);
    rd(9'h0bc, 32'h1);
    // Each receive error keeps the frame out of both broadcast counters
    for (i = 0; i < 5; i++) begin
      frame(1'b0, l, BC | (9'h010 >> i));
      rd(9'h0bc, 32'h1);
    end
    rd(9'h0b0, oct);
    rd(9'h0c8, 32'h0001_0001);
    rd(9'h0cc, 32'h0001_0001);
    // A plain multicast pause frame stays out of the broadcast count
    frame(1'b0, l, 9'h0a0);
    rd(9'h0bc, 32'h1);
    rd(9'h0b8, 32'h1);
    rd(9'h0c4, 32'h0001_0000);
    // Only good frames to the all-ones address count as broadcast
    frame(1'b1, 16'h003c, 9'h01a);
    frame(1'b1, 16'h003c, 9'h014);
    frame(1'b1, 16'h003c, 9'h008);
    rd(9'h0f4, 32'h0001_0000);
    rd(9'h0d8, 32'h40);
    // Masked frame counter holds while the octet counter runs on
    mask = 25'h20;
    frame(1'b0, l, BC | VL);
    oct = oct + 32'(l) + 32'h4;
    rd(9'h0b0, oct);
    rd(9'h0bc, 32'h1);
    mask = '0;
    gen = 1'b0;
    frame(1'b0, l, BC | VL);
    rd(9'h0b0, oct);
    gen = 1'b1;
    wr(9'h0bc, 4'h3, 32'h0000_ffff);
    frame(1'b0, 16'h003c, BC);
    rd(9'h0bc, 32'h0);
    wr(9'h0b0, 4'hf, 32'hffff_fff0);
    frame(1'b0, 16'h003c, BC | VL);
    rd(9'h0b0, 32'h30);
    chk("flag", flag, 32'h0);
    wr(9'h0bc, 4'h3, 32'h0000_bfff);
    frame(1'b0, 16'h003c, BC);
    rd(9'h0bc, 32'hc000);
    chk("flag", flag, 32'h1);
    wr(9'h0bc, 4'h3, 32'h0000_ffff);
    frame(1'b0, 16'h003c, BC);
    rd(9'h0bc, 32'h0);
    chk("flag", flag, 32'h1);
    tk;
    clr = 1'b1;
    tk;
    clr = 1'b0;
    chk("flag", flag, 32'h0);
    wr(9'h0b0, 4'hf, 32'hbfff_ffc0);
    frame(1'b0, 16'h003c, BC | VL);
    rd(9'h0b0, 32'hc000_0000);
    chk("flag", flag, 32'h1);
    // Window decode: I/O space is 256 bytes, memory upper half reads zero
    io_sel = 1'b1;
    mem_sel = 1'b0;
    rd(9'h0bc, 32'h1);
    rd(9'h1bc, 32'h0);
    io_en = 1'b0;
    rd(9'h0bc, 32'h0);
    io_en = 1'b1;
    io_sel = 1'b0;
    mem_sel = 1'b1;
    mem_en = 1'b0;
    rd(9'h0bc, 32'h0);
    mem_en = 1'b1;
    rd(9'h1bc, 32'h0);
    // Random transmit event pulses; late collisions tallied here
    repeat (40) begin
      tk;
      tx_ev = 7'($random(seed));
      n += int'(tx_ev[1]);
    end
    tk;
    tx_ev = 7'h00;
    rd(9'h0e8, 32'(n));
    // Reset again mid-run: counters and the sticky flag must clear
    tk;
    sys_rst = 1'b1;
    tk;
    sys_rst = 1'b0;
    rd(9'h0e8, 32'h0);
    chk("flag", flag, 32'h0);
    tk;
    conclude;
  end
endmodule
